/* File: rtl/lstc_pkg.sv */
/*
 link self-test checker package: register offsets, field layouts, timing counts, types.
 assumes a single 25 MHz system clock.
*/
package lstc_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] FWD_ERR_COUNT_OFFSET = 8'h25;
    localparam logic [7:0] SELF_TEST_CFG_OFFSET = 8'h24;
    localparam int         CFG_ENABLE_BIT       = 0;
    localparam int         CFG_OSC_SEL_BIT      = 1;
    localparam logic [7:0] CFG_RESET_VALUE      = 8'h00;
    localparam logic [7:0] ERR_COUNT_RESET      = 8'h00;
    localparam logic [7:0] ERR_COUNT_MAX        = 8'hff;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int         FRAME_BITS           = 35;
    localparam int         PAYLOAD_LO           = 1;
    localparam int         PAYLOAD_HI           = 35;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int         CLOCK_MHZ            = 25;
    localparam int         OSC_FREQ_MHZ         = 33;
    localparam int         PASS_LOW_CYCLES      = 1;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_WAKE  = 4'b0010,
        ST_CHECK = 4'b0100,
        ST_DONE  = 4'b1000
    } lstc_state_t;

    typedef struct packed {
        logic                  valid;
        logic [FRAME_BITS-1:0] payload;
    } lstc_frame_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lstc_reg_req_t;
endpackage

/* File: rtl/lstc_sync.sv */
/*
 three-flop synchroniser for asynchronous pin inputs.
 output changes only when the second and third stages agree.
*/
`timescale 1ns/1ps
module lstc_sync
(
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic pin,
    output logic      level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ------------------------------------------------------------
    // stages
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            s1_q  <= 1'b0;
            s2_q  <= 1'b0;
            s3_q  <= 1'b0;
            level <= 1'b0;
        end
        else
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                level <= s3_q;
        end
    end
endmodule

/* File: rtl/lstc_err_counter.sv */
/*
 saturating forward error counter.
 clear wins over increment; lock loss and new test entry both clear it.
*/
`timescale 1ns/1ps
module lstc_err_counter
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic             clear,
    input  wire logic             incr,
    output logic [WIDTH-1:0]      count
);
    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (incr && count != {WIDTH{1'b1}})
            count <= count + 1'b1;
    end
endmodule

/* File: rtl/lstc_checker.sv */
/*
 link self-test checker, deserializer side.
 assumes the link layer delivers recovered frames with a lock flag, synchronous to clock,
 and that the back channel accepts one-cycle request pulses.
*/
//
// Operation
// - self test starts when the enable pin or the config register enable bit is set.
// - test clock is the internal oscillator when pin or register selects it and no pixel clock is present, otherwise the pixel clock.
// - on activation a self-test enable indication is sent over the back channel.
// - a wake request is sent over the back channel if the serializer is asleep.
// - with both ends in test and lock acquired, pass goes high and checking starts; the checker already sets pass high in the wake state, before lock.
// - each frame with an error in payload bits 1 to 35 pulses pass low briefly.
// - after the test, pass holds the last result until a new test or power down.
// - the error count clears whenever lock is lost.
// - the test lasts as long as the enable pin or the config register enable bit is set; clearing both ends it.
// - lock status stays valid for the whole test.
// - leaving self test steps the adaptive equalizer to its next setting.
// - forward errors after lock are recorded in the register at forward_error_count.
`timescale 1ns/1ps
module lstc_checker
(
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 self_test_enable_pin,
    input  wire logic                 self_test_clock_select,
    input  wire logic                 pixel_clock_present,
    input  wire logic                 serializer_awake,
    input  wire logic                 serializer_in_test,
    input  wire logic                 link_lock,
    input  wire lstc_pkg::lstc_frame_t frame,
    input  wire lstc_pkg::lstc_reg_req_t reg_req,
    output logic [7:0]                reg_rdata,
    output logic                      pass,
    output logic                      lock_out,
    output logic                      test_active,
    output logic                      use_internal_oscillator,
    output logic                      bc_test_enable,
    output logic                      bc_wake,
    output logic                      equalizer_step
);
    import lstc_pkg::*;

    logic        pin_level;
    logic [7:0]  cfg_q;
    logic        enable_req;
    logic        enable_req_q;
    lstc_state_t state_q;
    logic        frame_err;
    logic        result_q;
    logic        cnt_clear;
    logic [7:0]  err_count;
    logic        lock_q;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    lstc_sync u_sync
    (
        .clock (clock),
        .reset (reset),
        .pin   (self_test_enable_pin),
        .level (pin_level)
    );

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            cfg_q <= CFG_RESET_VALUE;
        else if (reg_req.wr && reg_req.addr == SELF_TEST_CFG_OFFSET)
            cfg_q <= reg_req.wdata;
    end

    assign enable_req = pin_level | cfg_q[CFG_ENABLE_BIT];

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                FWD_ERR_COUNT_OFFSET: reg_rdata <= err_count;
                SELF_TEST_CFG_OFFSET: reg_rdata <= cfg_q;
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock source select
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            use_internal_oscillator <= 1'b0;
        else
            use_internal_oscillator <= !pixel_clock_present &&
                (self_test_clock_select || cfg_q[CFG_OSC_SEL_BIT]);
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            enable_req_q <= 1'b0;
        else
            enable_req_q <= enable_req;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            state_q <= ST_IDLE;
        else if (!enable_req)
            state_q <= (state_q == ST_IDLE) ? ST_IDLE : ST_DONE;
        else
        begin
            unique case (state_q)
                ST_IDLE, ST_DONE: state_q <= ST_WAKE;
                ST_WAKE:
                    if (serializer_in_test && link_lock)
                        state_q <= ST_CHECK;
                ST_CHECK: state_q <= ST_CHECK;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            bc_test_enable <= 1'b0;
            bc_wake        <= 1'b0;
            test_active    <= 1'b0;
            equalizer_step <= 1'b0;
        end
        else
        begin
            bc_test_enable <= enable_req;
            bc_wake        <= enable_req && !enable_req_q && !serializer_awake;
            test_active    <= enable_req;
            equalizer_step <= !enable_req && enable_req_q;
        end
    end

    // ------------------------------------------------------------
    // payload check
    // ------------------------------------------------------------
    assign frame_err = (state_q == ST_CHECK) && link_lock && enable_req && frame.valid &&
        (|frame.payload[PAYLOAD_HI-1:PAYLOAD_LO-1]);

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            result_q <= 1'b1;
        else if (state_q == ST_WAKE)
            result_q <= 1'b1;
        else if (frame_err)
            result_q <= 1'b0;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            pass <= 1'b1;
        else if (state_q == ST_CHECK && enable_req)
            pass <= !frame_err;
        else if (state_q == ST_DONE)
            pass <= result_q;
        else if (state_q == ST_WAKE)
            pass <= 1'b1;
    end

    assign cnt_clear = !link_lock || (enable_req && !enable_req_q);

    lstc_err_counter #(.WIDTH(8)) u_cnt
    (
        .clock (clock),
        .reset (reset),
        .clear (cnt_clear),
        .incr  (frame_err),
        .count (err_count)
    );

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            lock_q   <= 1'b0;
            lock_out <= 1'b0;
        end
        else
        begin
            lock_q   <= link_lock;
            lock_out <= link_lock;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_lock_clear;
        @(posedge clock) disable iff (reset)
        !link_lock |=> err_count == 8'h00;
    endproperty
    a_lock_clear: assert property (p_lock_clear) else $error("count not cleared");

    property p_err_pulse;
        @(posedge clock) disable iff (reset)
        frame_err |=> !pass;
    endproperty
    a_err_pulse: assert property (p_err_pulse) else $error("pass not low");

    property p_sat;
        @(posedge clock) disable iff (reset)
        (err_count == ERR_COUNT_MAX && !cnt_clear) |=> err_count == ERR_COUNT_MAX;
    endproperty
    a_sat: assert property (p_sat) else $error("counter wrapped");

    property p_incr;
        @(posedge clock) disable iff (reset)
        (frame_err && !cnt_clear && err_count != ERR_COUNT_MAX) |=>
            err_count == $past(err_count) + 8'h01;
    endproperty
    a_incr: assert property (p_incr) else $error("no increment");

    property p_hold;
        @(posedge clock) disable iff (reset)
        (state_q == ST_DONE && !enable_req) |=> pass == result_q;
    endproperty
    a_hold: assert property (p_hold) else $error("result not held");

    property p_start;
        @(posedge clock) disable iff (reset)
        (state_q == ST_WAKE && enable_req && serializer_in_test && link_lock) |=>
            state_q == ST_CHECK;
    endproperty
    a_start: assert property (p_start) else $error("check not started");

    property p_bc;
        @(posedge clock) disable iff (reset)
        $rose(enable_req) |=> bc_test_enable;
    endproperty
    a_bc: assert property (p_bc) else $error("no back channel enable");

    property p_eq;
        @(posedge clock) disable iff (reset)
        $fell(enable_req) |=> equalizer_step ##1 !equalizer_step;
    endproperty
    a_eq: assert property (p_eq) else $error("equalizer not stepped");

    property p_lock;
        @(posedge clock) disable iff (reset)
        test_active |-> lock_out == lock_q;
    endproperty
    a_lock: assert property (p_lock) else $error("lock output stale");

    property p_wake;
        @(posedge clock) disable iff (reset)
        ($rose(enable_req) && !serializer_awake) |=> bc_wake;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake request");

    property p_restart;
        @(posedge clock) disable iff (reset)
        state_q == ST_WAKE |=> pass;
    endproperty
    a_restart: assert property (p_restart) else $error("pass not raised");

    property p_entry_clear;
        @(posedge clock) disable iff (reset)
        $rose(enable_req) |=> err_count == 8'h00;
    endproperty
    a_entry_clear: assert property (p_entry_clear) else $error("count not cleared");

    property p_clean;
        @(posedge clock) disable iff (reset)
        (state_q == ST_CHECK && enable_req && !frame_err) |=> pass;
    endproperty
    a_clean: assert property (p_clean) else $error("pass low on clean frame");

    property p_osc;
        @(posedge clock) disable iff (reset)
        pixel_clock_present |=> !use_internal_oscillator;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator chosen with clock");

    property p_idle;
        @(posedge clock) disable iff (reset)
        !enable_req |=> !test_active && !bc_test_enable;
    endproperty
    a_idle: assert property (p_idle) else $error("test not ended");
endmodule

/* File: tb/lstc_serializer_model.sv */
/*
 behavioural remote serializer: wakes on request, follows test enable, sends frames.
 assumes the checker's back-channel outputs are registered on the same clock.
*/
`timescale 1ns/1ps
module lstc_serializer_model
(
    input  wire logic                  clock,
    input  wire logic                  reset,
    input  wire logic                  bc_test_enable,
    input  wire logic                  bc_wake,
    input  wire logic                  drop_lock,
    input  wire logic [34:0]           err_mask,
    input  wire logic                  bc_crc_err,
    input  wire logic [3:0]            config_straps,
    output logic [7:0]                 bc_crc_count,
    output logic                       serializer_awake,
    output logic                       serializer_in_test,
    output logic                       link_lock,
    output lstc_pkg::lstc_frame_t      frame
);
    import lstc_pkg::*;
    logic [1:0]  slot_q;
    logic [34:0] idle_q;
    logic        test_req;

    assign test_req = bc_test_enable && serializer_awake && config_straps == 4'h1;
    // ------------------------------------------------------------
    // power, test mode and lock
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            serializer_awake   <= 1'b0;
            serializer_in_test <= 1'b0;
            link_lock          <= 1'b0;
        end
        else
        begin
            if (bc_wake)
                serializer_awake <= 1'b1;
            serializer_in_test <= test_req;
            link_lock          <= serializer_awake && !drop_lock;
        end
    end
    // ------------------------------------------------------------
    // frames: valid frames carry zero payload, corrupted only on command; idle slots alternate all zeros and all ones
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            slot_q <= 2'h0;
            idle_q <= 35'h0;
            frame  <= '0;
        end
        else
        begin
            slot_q        <= slot_q + 2'h1;
            idle_q        <= ~idle_q;
            frame.valid   <= serializer_awake && slot_q == 2'h3;
            frame.payload <= (serializer_awake && slot_q == 2'h3) ? err_mask : idle_q;
        end
    end
    // ------------------------------------------------------------
    // back-channel crc error record, back-channel lock is the awake state
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            bc_crc_count <= 8'h00;
        else if (test_req && !serializer_in_test)
            bc_crc_count <= 8'h00;
        else if (serializer_in_test && serializer_awake && bc_crc_err)
            bc_crc_count <= bc_crc_count + 8'h01;
    end
endmodule

/* File: tb/test_lstc_checker.sv */
/*
 testbench for the link self-test checker.
 assumes the serializer model in tb/ and the checker's own embedded assertions.
*/
`timescale 1ns/1ps
module test_lstc_checker;
    import lstc_pkg::*;
    logic clock, reset, self_test_enable_pin, self_test_clock_select, pixel_clock_present;
    logic serializer_awake, serializer_in_test, link_lock, drop_lock, pass, lock_out;
    logic test_active, use_internal_oscillator, bc_test_enable, bc_wake, equalizer_step;
    logic [34:0]   err_mask;
    logic [7:0]    reg_rdata;
    logic          bc_crc_err;
    logic [3:0]    config_straps;
    logic [7:0]    bc_crc_count;
    lstc_frame_t   frame;
    lstc_reg_req_t reg_req;
    int bad_count = 0, cmp_count = 0, wake_cnt = 0, step_cnt = 0, fall_cnt = 0, n, f0;
    logic pass_prev = 1'b1;

    lstc_checker u_lstc_checker (.clock(clock), .reset(reset),
        .self_test_enable_pin(self_test_enable_pin), .self_test_clock_select(self_test_clock_select),
        .pixel_clock_present(pixel_clock_present), .serializer_awake(serializer_awake),
        .serializer_in_test(serializer_in_test), .link_lock(link_lock), .frame(frame),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .pass(pass), .lock_out(lock_out),
        .test_active(test_active), .use_internal_oscillator(use_internal_oscillator),
        .bc_test_enable(bc_test_enable), .bc_wake(bc_wake), .equalizer_step(equalizer_step));
    lstc_serializer_model u_lstc_serializer_model (.clock(clock), .reset(reset),
        .bc_test_enable(bc_test_enable), .bc_wake(bc_wake), .drop_lock(drop_lock),
        .err_mask(err_mask), .bc_crc_err(bc_crc_err), .config_straps(config_straps),
        .bc_crc_count(bc_crc_count), .serializer_awake(serializer_awake),
        .serializer_in_test(serializer_in_test), .link_lock(link_lock), .frame(frame));

    always #20 clock = ~clock;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clock);
        reg_req <= '0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clock);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clock);
        reg_req <= '0;
        @(negedge clock);
        chk(what, exp, reg_rdata);
    endtask
    task automatic wait_check;
        for (n = 0; n < 40 && !(serializer_in_test === 1'b1 && link_lock === 1'b1); n++)
            @(posedge clock);
        if (n == 40)
            bad_count++;
        repeat (3) @(posedge clock);
    endtask
    task automatic wait_idle;
        for (n = 0; n < 10 && test_active !== 1'b0; n++)
            @(posedge clock);
        if (n == 10)
            bad_count++;
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic send_errs(input int cnt, input logic [34:0] mask);
        int seen;
        seen = 0;
        @(posedge clock);
        err_mask <= mask;
        while (seen < cnt)
        begin
            @(posedge clock);
            if (frame.valid === 1'b1 && frame.payload != 35'h0)
                seen++;
        end
        err_mask <= 35'h0;
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------------------
    // monitor of pulses
    // ------------------------------------------------------------
    always @(posedge clock)
    begin
        if (reset === 1'b0)
        begin
            if (bc_wake === 1'b1)
                wake_cnt++;
            if (equalizer_step === 1'b1)
                step_cnt++;
            if (pass_prev === 1'b1 && pass === 1'b0)
                fall_cnt++;
            pass_prev = pass;
        end
    end
    initial
    begin
        #200us;
        bad_count++;
        complete_run;
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        reset = 1'b1;
        self_test_enable_pin = 1'b0;
        self_test_clock_select = 1'b0;
        pixel_clock_present = 1'b1;
        drop_lock = 1'b0;
        err_mask = 35'h0;
        bc_crc_err = 1'b0;
        config_straps = 4'h1;
        reg_req = '0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(negedge clock);
        chk("pass", 8'h01, {7'h0, pass});
        rd_chk("error count", FWD_ERR_COUNT_OFFSET, ERR_COUNT_RESET);
        rd_chk("config", SELF_TEST_CFG_OFFSET, CFG_RESET_VALUE);
        rd_chk("unmapped", 8'h10, 8'h00);
        $display("test reset_values done");
        @(posedge clock);
        self_test_enable_pin <= 1'b1;
        for (n = 0; n < 10 && bc_test_enable !== 1'b1; n++)
            @(posedge clock);
        chk("bc enable", 8'h01, {7'h0, bc_test_enable});
        wait_check;
        chk("wake pulses", 8'h01, 8'(wake_cnt));
        chk("pass start", 8'h01, {7'h0, pass});
        chk("test active", 8'h01, {7'h0, test_active});
        chk("oscillator", 8'h00, {7'h0, use_internal_oscillator});
        send_errs(1, 35'h1);
        send_errs(2, 35'h4_0000_0000);
        chk("pass pulses", 8'h03, 8'(fall_cnt));
        rd_chk("error count", FWD_ERR_COUNT_OFFSET, 8'h03);
        reg_write(FWD_ERR_COUNT_OFFSET, 8'h7e);
        rd_chk("count read only", FWD_ERR_COUNT_OFFSET, 8'h03);
        chk("lock out", {7'h0, link_lock}, {7'h0, lock_out});
        @(posedge clock);
        bc_crc_err <= 1'b1;
        repeat (2) @(posedge clock);
        bc_crc_err <= 1'b0;
        @(negedge clock);
        chk("crc count", 8'h02, bc_crc_count);
        @(posedge clock);
        self_test_enable_pin <= 1'b0;
        wait_idle;
        chk("test ended", 8'h00, {7'h0, test_active});
        chk("eq steps", 8'h01, 8'(step_cnt));
        chk("pass held low", 8'h00, {7'h0, pass});
        chk("crc count kept", 8'h02, bc_crc_count);
        $display("test pin_errors done");
        @(posedge clock);
        self_test_clock_select <= 1'b1;
        pixel_clock_present <= 1'b0;
        reg_write(SELF_TEST_CFG_OFFSET, 8'h03);
        wait_check;
        chk("oscillator", 8'h01, {7'h0, use_internal_oscillator});
        chk("wake pulses", 8'h01, 8'(wake_cnt));
        chk("pass restart", 8'h01, {7'h0, pass});
        chk("crc count new test", 8'h00, bc_crc_count);
        rd_chk("count new test", FWD_ERR_COUNT_OFFSET, 8'h00);
        send_errs(260, 35'h2);
        rd_chk("count saturated", FWD_ERR_COUNT_OFFSET, ERR_COUNT_MAX);
        @(posedge clock);
        drop_lock <= 1'b1;
        repeat (4) @(posedge clock);
        rd_chk("count lock loss", FWD_ERR_COUNT_OFFSET, 8'h00);
        @(posedge clock);
        drop_lock <= 1'b0;
        reg_write(SELF_TEST_CFG_OFFSET, 8'h00);
        wait_idle;
        chk("eq steps", 8'h02, 8'(step_cnt));
        $display("test register_saturate done");
        f0 = fall_cnt;
        @(posedge clock);
        self_test_enable_pin <= 1'b1;
        wait_check;
        repeat (40) @(posedge clock);
        self_test_enable_pin <= 1'b0;
        wait_idle;
        chk("test ended", 8'h00, {7'h0, test_active});
        chk("clean pulses", 8'(f0), 8'(fall_cnt));
        chk("pass held high", 8'h01, {7'h0, pass});
        $display("test clean_run done");
        complete_run;
    end
endmodule
